// ===== fosp_pkg.sv
package fosp_pkg;

  // ==========================================================================
  // Register map (byte addresses).
  // ==========================================================================
  localparam logic [15:0] FOSP_ADDR_OPTION  = 16'h1821;
  localparam logic [15:0] FOSP_ADDR_CONFIG  = 16'h1823;
  localparam logic [15:0] FOSP_ADDR_PROTECT = 16'h1824;
  localparam logic [15:0] FOSP_ADDR_KEY     = 16'h1828;
  localparam logic [15:0] FOSP_ADDR_STATUS  = 16'h182C;
  localparam logic [15:0] FOSP_ADDR_CMD     = 16'h1830;

  // ==========================================================================
  // Field layouts and values.
  // ==========================================================================
  localparam int          FOSP_OPT_BACKDOOR   = 7;
  localparam int          FOSP_OPT_REDIR_OFF  = 6;
  localparam logic [7:0]  FOSP_OPT_MASK       = 8'hC3;
  localparam logic [7:0]  FOSP_CFG_MASK       = 8'hE0;
  localparam int          FOSP_CFG_KEY_WRITE_ACCESS     = 5;
  localparam int          FOSP_PROT_DISABLE   = 0;
  localparam logic [1:0]  FOSP_SEC_UNSECURED  = 2'h2;
  localparam logic [7:0]  FOSP_CFG_RESET      = 8'h00;
  localparam logic [15:0] FOSP_KEY_BASE       = 16'hFFB0;
  localparam logic [15:0] FOSP_KEY_LAST       = 16'hFFB7;
  localparam logic [2:0]  FOSP_KEY_LAST_IDX   = 3'h7;
  localparam int          FOSP_KEY_BYTES      = 8;
  localparam int          FOSP_ST_VIOL        = 0;
  localparam int          FOSP_ST_UNSEC       = 1;
  localparam int          FOSP_ST_LAUNCH      = 2;
  localparam int          FOSP_CMD_LAUNCH_BIT = 0;
  localparam int          FOSP_CMD_PROG_BIT   = 1;
  localparam int          FOSP_ST_BLANK_BIT   = 3;
  localparam logic [8:0]  FOSP_PAGE_LOW_ONES  = 9'h1FF;

endpackage

// ===== fosp_core.sv
// Local design decision: the APB slave port.
`timescale 1ns/100ps

module fosp_core
  import fosp_pkg::*;
(
  input  wire logic        clk,                 // Bus clock, 40 MHz.
  input  wire logic        rst,                 // Synchronous MCU reset.
  input  wire logic        ce,                  // Clock enable; low freezes.
  input  wire logic [7:0]  nv_option_byte,      // Stored option byte.
  input  wire logic [7:0]  nv_protect_byte,     // Stored protection byte.
  input  wire logic [63:0] nv_backdoor_key,     // Stored key, byte 0 low.
  input  wire logic        background_debug_commands, // Access is debug.
  input  wire logic        psel,                // APB select.
  input  wire logic        penable,             // APB enable.
  input  wire logic        pwrite,              // APB direction.
  input  wire logic [15:0] paddr,               // APB byte address.
  input  wire logic [31:0] pwdata,              // APB write data.
  output logic      [31:0] prdata,              // APB read data.
  output logic             pready,              // APB ready.
  output logic             pslverr,             // APB error.
  input  wire logic [15:0] mem_addr,            // Memory access address.
  input  wire logic        mem_req,             // Memory access request.
  input  wire logic        mem_from_debug,      // Access from debug source.
  output logic             mem_allow,           // Memory access permitted.
  input  wire logic        blank_done,          // Blank check finished.
  input  wire logic        blank_ok,            // Whole array was erased.
  output logic             vector_redirect_off, // Vector redirection off.
  output logic             security_secure,     // Part is secured.
  output logic             cmd_launch,          // Accepted flash command.
  output logic      [15:0] cmd_addr,            // Command target address.
  output logic      [7:0]  cmd_data             // Command write data.
);
  import fosp_pkg::*;

  // ==========================================================================
  // Register state.
  // ==========================================================================
  logic [7:0]  option_reg, next_option_reg;
  logic [7:0]  flash_config, next_flash_config;
  logic [7:0]  protect_reg, next_protect_reg;
  logic [1:0]  security_code, next_security_code;
  logic [2:0]  key_idx, next_key_idx;
  logic        key_ok, next_key_ok;
  logic        viol, next_viol;
  logic        launch_seen, next_launch_seen;
  logic        load_pend, next_load_pend;
  logic        next_cmd_launch;
  logic [15:0] next_cmd_addr;
  logic [7:0]  next_cmd_data;
  logic [31:0] next_prdata;

  logic        wr_acc, rd_acc, key_window, user_key_wr, cmd_wr, hit_prot;
  logic        mapped;
  logic [7:0]  key_byte [FOSP_KEY_BYTES];

  assign wr_acc = psel && penable && pwrite && ce;
  assign rd_acc = psel && !penable && !pwrite && ce;

  // Key bytes laid out for ascending comparison.
  for (genvar g = 0; g < FOSP_KEY_BYTES; g++) begin : g_key
    assign key_byte[g] = nv_backdoor_key[8*g +: 8];
  end

  function automatic logic is_unsecured(input logic [1:0] code);
    return code == FOSP_SEC_UNSECURED;
  endfunction

  function automatic logic is_protected(input logic [7:0] prot,
                                        input logic [15:0] addr);
    logic [15:0] last_free;
    last_free = {prot[7:1], FOSP_PAGE_LOW_ONES};
    return !prot[FOSP_PROT_DISABLE] && (addr > last_free);
  endfunction

  assign key_window  = (paddr >= FOSP_KEY_BASE) && (paddr <= FOSP_KEY_LAST);
  // Debug commands never feed the key comparator.
  assign user_key_wr = wr_acc && key_window &&
                       flash_config[FOSP_CFG_KEY_WRITE_ACCESS] &&
                       !background_debug_commands;
  assign cmd_wr      = wr_acc && ((key_window &&
                       !flash_config[FOSP_CFG_KEY_WRITE_ACCESS]) ||
                       (paddr == FOSP_ADDR_CMD));
  assign hit_prot    = is_protected(protect_reg, paddr);
  assign mapped      = key_window || paddr == FOSP_ADDR_OPTION ||
                       paddr == FOSP_ADDR_CONFIG ||
                       paddr == FOSP_ADDR_PROTECT ||
                       paddr == FOSP_ADDR_STATUS || paddr == FOSP_ADDR_CMD;

  // Zero-wait slave; unmapped addresses answer with an error.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign vector_redirect_off = option_reg[FOSP_OPT_REDIR_OFF];
  assign security_secure     = !is_unsecured(security_code);
  // Secure parts deny debug-sourced memory reads and writes.
  assign mem_allow = mem_req && !(security_secure && mem_from_debug);

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  always_comb begin
    next_option_reg    = option_reg;
    next_flash_config  = flash_config;
    next_protect_reg   = protect_reg;
    next_security_code = security_code;
    next_key_idx       = key_idx;
    next_key_ok        = key_ok;
    next_viol          = viol;
    next_launch_seen   = launch_seen;
    next_load_pend     = 1'b0;
    next_cmd_launch    = 1'b0;
    next_cmd_addr      = cmd_addr;
    next_cmd_data      = cmd_data;
    next_prdata        = prdata;
    if (load_pend) begin
      // Nonvolatile bytes are captured the cycle after reset releases.
      next_option_reg    = nv_option_byte & FOSP_OPT_MASK;
      next_protect_reg   = nv_protect_byte;
      next_security_code = nv_option_byte[1:0];
    end else if (ce) begin
      if (wr_acc && paddr == FOSP_ADDR_CONFIG) begin
        next_flash_config = pwdata[7:0] & FOSP_CFG_MASK;
      end
      if (wr_acc && paddr == FOSP_ADDR_PROTECT &&
          background_debug_commands) begin
        next_protect_reg = pwdata[7:0];
      end
      if (wr_acc && paddr == FOSP_ADDR_STATUS && pwdata[FOSP_ST_VIOL]) begin
        next_viol = 1'b0;
      end
      if (user_key_wr) begin
        // Bytes must arrive at ascending addresses; a miss restarts.
        if (paddr[2:0] == key_idx) begin
          next_key_ok  = (key_idx == 3'h0 ? 1'b1 : key_ok) &&
                         (pwdata[7:0] == key_byte[key_idx]);
          next_key_idx = key_idx + 3'h1;
          if (key_idx == FOSP_KEY_LAST_IDX) begin
            next_key_ok = 1'b0;
            if (key_ok && pwdata[7:0] == key_byte[key_idx] &&
                option_reg[FOSP_OPT_BACKDOOR]) begin
              next_security_code = FOSP_SEC_UNSECURED;
            end
          end
        end else begin
          next_key_idx = 3'h0;
          next_key_ok  = 1'b0;
        end
      end
      // A refused command still counts as seen, so software can poll for it.
      if (cmd_wr) begin
        if (pwdata[FOSP_CMD_PROG_BIT] && hit_prot) begin
          next_viol        = 1'b1;
          next_launch_seen = 1'b1;
        end else if (paddr != FOSP_ADDR_CMD) begin
          next_cmd_launch  = 1'b1;
          next_cmd_addr    = paddr;
          next_cmd_data    = pwdata[7:0];
          next_launch_seen = 1'b1;
        end
      end
      // A blank check can only release security; it never secures the part.
      if (blank_done && blank_ok) begin
        next_security_code = FOSP_SEC_UNSECURED;
      end
      if (rd_acc) begin
        next_prdata = 32'h0000_0000;
        case (paddr)
          FOSP_ADDR_OPTION: begin
            // The security field shows the live code, which unlocks move.
            next_prdata[7:0] = {option_reg[7:2], security_code};
          end
          FOSP_ADDR_CONFIG:  next_prdata[7:0] = flash_config;
          FOSP_ADDR_PROTECT: next_prdata[7:0] = protect_reg;
          FOSP_ADDR_STATUS: begin
            next_prdata[FOSP_ST_VIOL]   = viol;
            next_prdata[FOSP_ST_UNSEC]  = is_unsecured(security_code);
            next_prdata[FOSP_ST_LAUNCH] = launch_seen;
          end
          default:           next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      option_reg    <= 8'h00;
      flash_config  <= FOSP_CFG_RESET;
      protect_reg   <= 8'h00;
      security_code <= 2'h0;
      key_idx       <= 3'h0;
      key_ok        <= 1'b0;
      viol          <= 1'b0;
      launch_seen   <= 1'b0;
      load_pend     <= 1'b1;
      cmd_launch    <= 1'b0;
      cmd_addr      <= 16'h0000;
      cmd_data      <= 8'h00;
      prdata        <= 32'h0000_0000;
    end else begin
      option_reg    <= next_option_reg;
      flash_config  <= next_flash_config;
      protect_reg   <= next_protect_reg;
      security_code <= next_security_code;
      key_idx       <= next_key_idx;
      key_ok        <= next_key_ok;
      viol          <= next_viol;
      launch_seen   <= next_launch_seen;
      load_pend     <= next_load_pend;
      cmd_launch    <= next_cmd_launch;
      cmd_addr      <= next_cmd_addr;
      cmd_data      <= next_cmd_data;
      prdata        <= next_prdata;
    end
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  sequence s_key_done;
    user_key_wr && paddr[2:0] == FOSP_KEY_LAST_IDX && key_idx == paddr[2:0];
  endsequence

  a_option_load: assert property (@(posedge clk) disable iff (rst)
    load_pend |=> option_reg == (($past(nv_option_byte)) & FOSP_OPT_MASK))
    else $error("option byte not loaded");
  a_option_zero: assert property (@(posedge clk) disable iff (rst)
    option_reg[5:2] == 4'h0) else $error("option reserved bits set");
  a_option_ro: assert property (@(posedge clk) disable iff (rst)
    !$past(load_pend) |-> $stable(option_reg))
    else $error("option register changed");
  a_backdoor_off: assert property (@(posedge clk) disable iff (rst)
    (s_key_done and !option_reg[FOSP_OPT_BACKDOOR] && !load_pend &&
     !(blank_done && blank_ok) && !is_unsecured(security_code))
    |=> !is_unsecured(security_code)) else $error("backdoor bypass");
  a_debug_key: assert property (@(posedge clk) disable iff (rst)
    background_debug_commands |-> !user_key_wr)
    else $error("debug wrote key");
  a_redirect: assert property (@(posedge clk) disable iff (rst)
    vector_redirect_off == option_reg[FOSP_OPT_REDIR_OFF])
    else $error("redirect mismatch");
  a_mem_block: assert property (@(posedge clk) disable iff (rst)
    (security_code != FOSP_SEC_UNSECURED && mem_from_debug) |-> !mem_allow)
    else $error("secure access leaked");
  a_blank_unsec: assert property (@(posedge clk) disable iff (rst)
    (blank_done && blank_ok && ce && !load_pend) |=>
    security_code == FOSP_SEC_UNSECURED) else $error("blank no unsec");
  a_cfg_zero: assert property (@(posedge clk) disable iff (rst)
    flash_config[4:0] == 5'h00) else $error("config low bits set");
  a_prot_user: assert property (@(posedge clk) disable iff (rst)
    (wr_acc && paddr == FOSP_ADDR_PROTECT && !background_debug_commands &&
     !load_pend) |=> $stable(protect_reg)) else $error("user prot write");
  a_prot_viol: assert property (@(posedge clk) disable iff (rst)
    (cmd_wr && pwdata[FOSP_CMD_PROG_BIT] && hit_prot && !load_pend) |=>
    (viol && !cmd_launch)) else $error("protected command ran");

  // ==========================================================================
  // Checks on loading, key entry and command routing.
  // ==========================================================================
  // The last byte arrives in order and every earlier byte matched.
  sequence s_key_match;
    s_key_done ##0 (key_ok && pwdata[7:0] == key_byte[FOSP_KEY_LAST_IDX]);
  endsequence

  // A byte at the wrong address sends the comparator back to byte zero.
  sequence s_key_skip;
    user_key_wr && !load_pend && paddr[2:0] != key_idx;
  endsequence

  a_key_unlock: assert property (@(posedge clk) disable iff (rst)
    (s_key_match ##0 (option_reg[FOSP_OPT_BACKDOOR] && !load_pend)) |=>
    is_unsecured(security_code)) else $error("key did not unlock");

  a_key_restart: assert property (@(posedge clk) disable iff (rst)
    s_key_skip |=> (key_idx == 3'h0 && !key_ok))
    else $error("key order not restarted");

  // A key write taken by the comparator must never also start a flash command.
  a_key_route: assert property (@(posedge clk) disable iff (rst)
    user_key_wr |=> !cmd_launch) else $error("key write launched");

  // An unprotected command-window write starts exactly one command.
  a_cmd_launch: assert property (@(posedge clk) disable iff (rst)
    (cmd_wr && key_window && !hit_prot && !load_pend) |=>
    (cmd_launch && cmd_addr == $past(paddr)))
    else $error("command not launched");

  // With the disable bit set no address may count as protected.
  a_prot_free: assert property (@(posedge clk) disable iff (rst)
    protect_reg[FOSP_PROT_DISABLE] |-> !hit_prot)
    else $error("disabled protection hit");

  // The load cycle wins over any bus traffic, so it needs no guard here.
  a_prot_load: assert property (@(posedge clk) disable iff (rst)
    load_pend |=> protect_reg == $past(nv_protect_byte))
    else $error("protect byte not loaded");

  a_sec_load: assert property (@(posedge clk) disable iff (rst)
    load_pend |=> security_code == $past(nv_option_byte[1:0]))
    else $error("security code not loaded");

  a_cfg_write: assert property (@(posedge clk) disable iff (rst)
    (wr_acc && paddr == FOSP_ADDR_CONFIG && !load_pend) |=>
    flash_config == ($past(pwdata[7:0]) & FOSP_CFG_MASK))
    else $error("config write lost");

  a_prot_debug: assert property (@(posedge clk) disable iff (rst)
    (wr_acc && paddr == FOSP_ADDR_PROTECT && background_debug_commands &&
     !load_pend) |=> protect_reg == $past(pwdata[7:0]))
    else $error("debug protect write lost");

  // Only a software clear or reset may drop the flag; a violation can only set it.
  a_viol_hold: assert property (@(posedge clk) disable iff (rst)
    (viol && !(wr_acc && paddr == FOSP_ADDR_STATUS)) |=> viol)
    else $error("violation flag dropped");

  // Low enable holds every register except the post-reset load and the one-cycle cmd_launch pulse.
  a_ce_freeze: assert property (@(posedge clk) disable iff (rst)
    (!ce && !load_pend) |=> ($stable(flash_config) && $stable(key_idx) &&
    $stable(viol) && $stable(security_code)))
    else $error("state moved while frozen");

endmodule

// ===== fosp_host.sv
`timescale 1ns/100ps

// ============================================================================
// APB master standing in for the core and the debug port.
// ============================================================================
module fosp_host (
  input  wire logic        clk,     // Bus clock.
  input  wire logic        pready,  // Slave ready.
  input  wire logic [31:0] prdata,  // Slave read data.
  input  wire logic        pslverr, // Slave error.
  output logic             psel,    // Select.
  output logic             penable, // Enable.
  output logic             pwrite,  // Direction.
  output logic      [15:0] paddr,   // Byte address.
  output logic      [31:0] pwdata,  // Write data.
  output logic             dbg      // Access comes from debug.
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h0000_0000;
    dbg     = 1'b0;
  end

  // Between transfers address and data are inverted so stale values never
  // pass for a request that is still held.
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [7:0] d, input logic g,
                      output logic [7:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {{24{1'b0}}, d};
    dbg     <= g;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata[7:0];
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= {{24{1'b1}}, ~d};
    @(posedge clk);
  endtask
endmodule

// ===== tb.sv
`timescale 1ns/100ps

module tb;
  import fosp_pkg::*;
  localparam logic [63:0] KEY = 64'h1122_3344_5566_7788;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  nv_opt = 8'h00;
  logic [7:0]  nv_prot = 8'h00;
  logic        mem_req = 1'b1;
  logic        mem_dbg = 1'b1;
  logic        blank_done = 1'b0;
  logic        blank_ok = 1'b0;
  logic        psel, penable, pwrite, dbg, pready, pslverr;
  logic        vector_redirect_off, security_secure, mem_allow, cmd_launch;
  logic [15:0] paddr, cmd_addr, last_addr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  cmd_data, rd;
  logic        er;
  int          fail_count = 0;
  int          samples_checked = 0;
  int          launches = 0;
  int          cycles = 0;

  always #12.5 clk = ~clk;

  fosp_host u_host (.clk(clk), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .dbg(dbg));

  fosp_core u_dut (.clk(clk), .rst(rst), .ce(1'b1),
    .nv_option_byte(nv_opt), .nv_protect_byte(nv_prot),
    .nv_backdoor_key(KEY), .background_debug_commands(dbg),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(16'h8000), .mem_req(mem_req), .mem_from_debug(mem_dbg),
    .mem_allow(mem_allow), .blank_done(blank_done), .blank_ok(blank_ok),
    .vector_redirect_off(vector_redirect_off),
    .security_secure(security_secure), .cmd_launch(cmd_launch),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data));

  // ==========================================================================
  // Monitors and shared tasks.
  // ==========================================================================
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cmd_launch === 1'b1) begin
      launches  <= launches + 1;
      last_addr <= cmd_addr;
    end
    if (cycles == 4000) begin
      fail_count++;
      wrap_up;
    end
  end

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic rd8(input logic [15:0] a);
    u_host.xfer(1'b0, a, 8'h00, 1'b0, rd, er);
  endtask

  task automatic wr8(input logic [15:0] a, input logic [7:0] d,
                     input logic g);
    u_host.xfer(1'b1, a, d, g, rd, er);
  endtask

  task automatic boot(input logic [7:0] o, input logic [7:0] p);
    nv_opt  <= o;
    nv_prot <= p;
    rst     <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic t_load;
    boot(8'hFE, 8'h5A);
    rd8(FOSP_ADDR_OPTION);
    chk("option", 8'hC2, rd);
    chk("redirect_off", 1'b1, vector_redirect_off);
    chk("secure", 1'b0, security_secure);
    rd8(FOSP_ADDR_PROTECT);
    chk("protect", 8'h5A, rd);
    wr8(FOSP_ADDR_OPTION, 8'h00, 1'b0);
    rd8(FOSP_ADDR_OPTION);
    chk("option", 8'hC2, rd);
    rd8(16'h1800);
    chk("slverr", 1'b1, er);
  endtask

  task automatic t_sec;
    for (int i = 0; i < 4; i++) begin
      boot({6'h20, i[1:0]}, 8'h01);
      chk("secure", (i != 2), security_secure);
      chk("mem_allow", (i == 2), mem_allow);
      chk("redirect_off", 1'b0, vector_redirect_off);
    end
  endtask

  task automatic t_cfg_prot;
    wr8(FOSP_ADDR_CONFIG, 8'hFF, 1'b0);
    rd8(FOSP_ADDR_CONFIG);
    chk("config", 8'hE0, rd);
    wr8(FOSP_ADDR_PROTECT, 8'h5B, 1'b0);
    rd8(FOSP_ADDR_PROTECT);
    chk("protect", 8'h01, rd);
    wr8(FOSP_ADDR_PROTECT, 8'hA4, 1'b1);
    rd8(FOSP_ADDR_PROTECT);
    chk("protect", 8'hA4, rd);
  endtask

  task automatic t_key(input logic en, input logic g, input logic sec);
    boot({en, 7'h00}, 8'h01);
    wr8(FOSP_ADDR_CONFIG, 8'h20, 1'b0);
    for (int i = 0; i < FOSP_KEY_BYTES; i++)
      wr8(FOSP_KEY_BASE + 16'(i), KEY[8*i+:8], g);
    chk("secure", sec, security_secure);
    rd8(FOSP_ADDR_OPTION);
    chk("option", {en, 5'h00, ~sec, 1'b0}, rd);
  endtask

  task automatic t_blank;
    boot(8'h00, 8'h01);
    blank_ok   <= 1'b1;
    blank_done <= 1'b1;
    @(posedge clk);
    blank_done <= 1'b0;
    blank_ok   <= 1'b0;
    @(posedge clk);
    chk("secure", 1'b0, security_secure);
  endtask

  task automatic t_cmd(input logic [7:0] p, input logic [15:0] a,
                       input logic hit);
    int n;
    boot(8'h82, p);
    wr8(FOSP_ADDR_CONFIG, 8'h00, 1'b0);
    n = launches;
    wr8(a, 8'h02, 1'b0);
    @(posedge clk);
    chk("launches", hit, launches - n);
    if (hit) chk("cmd_addr", a, last_addr);
    rd8(FOSP_ADDR_STATUS);
    chk("violation", !hit, rd[FOSP_ST_VIOL]);
  endtask

  initial begin
    t_load;
    t_sec;
    t_cfg_prot;
    t_key(1'b1, 1'b0, 1'b0);
    t_key(1'b0, 1'b0, 1'b1);
    t_key(1'b1, 1'b1, 1'b1);
    t_blank;
    t_cmd(8'h01, 16'hFFB0, 1'b1);
    t_cmd(8'hFC, 16'hFFB0, 1'b0);
    t_cmd(8'hFE, 16'hFFB7, 1'b1);
    wrap_up;
  end
endmodule
